// file: tsense_pkg.sv
// Functional notes
// - Power-up config: comparator, active-low, one fault
// - Power-up trip points 80 and 75 degrees
// - Power-up pointer selects temperature register
// - All defaults rewritable over the serial bus
// - Master makes clock; sensor never drives it
// - Nine clocks: eight data, one acknowledge
// - Master reads both bytes of 16-bit registers
// - Address 1001, strap pins, then direction
// - SDA falling, SCL high, is START
// - SDA rising, SCL high, is STOP
// - SDA changes only while SCL low
// - Idle bus: both high, sensor silent
// - Unlimited bytes between START and STOP
// - Acknowledge holds SDA low through ninth high
// - Addressed receiver acknowledges every byte
// - Master withholds final ack; sensor releases SDA
// - Byte after write address loads pointer
// - Reads use retained or newly set pointer
// - Temperature two bytes, configuration one byte
// - Mode bit: 0 comparator, 1 interrupt
package tsense_pkg;

   // ------------------------------------------------------------
   // Addressing and pointer codes
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_PREFIX = 4'h9;
   localparam logic [1:0] PTR_TEMP = 2'h0;
   localparam logic [1:0] PTR_CFG = 2'h1;
   localparam logic [1:0] PTR_LOWER = 2'h2;
   localparam logic [1:0] PTR_UPPER = 2'h3;

   // ------------------------------------------------------------
   // Reset values and configuration fields
   // ------------------------------------------------------------
   localparam logic [1:0] PTR_RESET = PTR_TEMP;
   localparam logic [4:0] CFG_RESET = 5'h00;
   localparam logic [15:0] UPPER_RESET = 16'h5000;
   localparam logic [15:0] LOWER_RESET = 16'h4B00;
   localparam int CFG_SHUTDOWN_BIT = 0;
   localparam int CFG_MODE_BIT = 1;
   localparam int CFG_POLARITY_BIT = 2;
   localparam int CFG_FAULT_LOW_BIT = 3;
   localparam int CFG_FAULT_HIGH_BIT = 4;
   localparam int TEMP_BITS = 9;

   // ------------------------------------------------------------
   // Master timing
   // ------------------------------------------------------------
   localparam int MCLK_PERIOD_NS = 50;
   localparam int SCL_PERIOD_NS = 2500;
   localparam int QUARTER_CYCLES =
      (SCL_PERIOD_NS + 4 * MCLK_PERIOD_NS - 1) / (4 * MCLK_PERIOD_NS);

endpackage

// file: twowire_if.sv
`timescale 1ns/1ps
interface twowire_if;
   // Open-drain outputs: value is always low, enable pulls the wire
   logic scl_m_o;
   logic scl_m_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_s_o;
   logic sda_s_oe;
   // Resolved wire levels with pull-ups
   logic scl;
   logic sda;

   assign scl = !(scl_m_oe && !scl_m_o);
   assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

   modport master (
      output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe,
      input sda, input scl
   );
   modport sensor (
      output sda_s_o, output sda_s_oe,
      input scl, input sda
   );
endinterface

// file: twowire_master.sv
`timescale 1ns/1ps
module twowire_master
   import tsense_pkg::*;
#(
   parameter int QUARTER = QUARTER_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Bus
   twowire_if.master bus,
   // Command
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_read,
   input wire logic cmd_set_ptr,
   input wire logic [1:0] cmd_pointer,
   input wire logic [2:0] cmd_target,
   input wire logic [1:0] cmd_nbytes,
   input wire logic [15:0] cmd_wdata,
   // Response
   output logic rsp_valid,
   output logic [15:0] rsp_rdata,
   output logic rsp_nack
);

   typedef enum {M_IDLE, M_START, M_BYTE, M_STOP} mst_t;
   typedef enum {K_ADDRW, K_PTR, K_WDATA, K_ADDRR, K_RDATA} kind_t;

   mst_t st_q;
   kind_t kind_q;
   logic [15:0] div_q;
   logic [1:0] qtr_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [1:0] left_q;
   logic rd_q, setp_q, rstart_q;
   logic [1:0] ptr_q;
   logic [2:0] tgt_q;
   logic [15:0] wdata_q;
   logic sda_m_q, sda_s_q;
   logic scl_oe_q, sda_oe_q;

   // ------------------------------------------------------------
   // Pin sampling and quarter-bit timing
   // ------------------------------------------------------------
   wire tick_w = (div_q == 16'(QUARTER - 1));
   wire slot_end_w = tick_w && (qtr_q == 2'h3);
   wire rx_kind_w = (kind_q == K_RDATA);
   wire ack_bit_w = (bit_q == 4'h8);
   wire peer_ack_w = !sda_s_q;
   wire last_rd_w = (left_q == 2'h1);
   wire scl_high_w = qtr_q[1];
   wire rw_flag_w = rstart_q || (rd_q && !setp_q);

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
      end else begin
         sda_m_q <= bus.sda;
         sda_s_q <= sda_m_q;
      end
   end

   // ------------------------------------------------------------
   // Pin drive per quarter
   // ------------------------------------------------------------
   logic scl_low_w, sda_low_w;
   always_comb begin
      scl_low_w = 1'b0;
      sda_low_w = 1'b0;
      unique case (st_q)
         M_IDLE: begin
            scl_low_w = 1'b0;
         end
         M_START: begin
            scl_low_w = (qtr_q == 2'h0) || (qtr_q == 2'h3);
            sda_low_w = qtr_q[1];
         end
         M_BYTE: begin
            scl_low_w = !scl_high_w;
            if (!ack_bit_w) begin
               sda_low_w = !rx_kind_w && !sh_q[7];
            end else begin
               sda_low_w = rx_kind_w && !last_rd_w;
            end
         end
         M_STOP: begin
            scl_low_w = (qtr_q == 2'h0);
            sda_low_w = !qtr_q[1];
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else begin
         scl_oe_q <= scl_low_w;
         sda_oe_q <= sda_low_w;
      end
   end

   assign bus.scl_m_o = 1'b0;
   assign bus.sda_m_o = 1'b0;
   assign bus.scl_m_oe = scl_oe_q;
   assign bus.sda_m_oe = sda_oe_q;
   assign cmd_ready = (st_q == M_IDLE);

   // ------------------------------------------------------------
   // Transfer sequencer
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_q <= M_IDLE;
         kind_q <= K_ADDRW;
         div_q <= 16'h0000;
         qtr_q <= 2'h0;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         left_q <= 2'h0;
         rd_q <= 1'b0;
         setp_q <= 1'b0;
         rstart_q <= 1'b0;
         ptr_q <= 2'h0;
         tgt_q <= 3'h0;
         wdata_q <= 16'h0000;
         rsp_valid <= 1'b0;
         rsp_rdata <= 16'h0000;
         rsp_nack <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         if (st_q == M_IDLE) begin
            div_q <= 16'h0000;
            qtr_q <= 2'h0;
            if (cmd_valid) begin
               st_q <= M_START;
               rd_q <= cmd_read;
               setp_q <= cmd_set_ptr;
               rstart_q <= 1'b0;
               ptr_q <= cmd_pointer;
               tgt_q <= cmd_target;
               left_q <= cmd_nbytes;
               wdata_q <= cmd_wdata;
               rsp_rdata <= 16'h0000;
               rsp_nack <= 1'b0;
            end
         end else if (tick_w) begin
            div_q <= 16'h0000;
            qtr_q <= qtr_q + 2'h1;
         end else begin
            div_q <= div_q + 16'h0001;
         end

         if (slot_end_w && st_q == M_START) begin
            st_q <= M_BYTE;
            bit_q <= 4'h0;
            kind_q <= rw_flag_w ? K_ADDRR : K_ADDRW;
            sh_q <= {ADDR_PREFIX, tgt_q, rw_flag_w};
         end else if (slot_end_w && st_q == M_STOP) begin
            st_q <= M_IDLE;
            rsp_valid <= 1'b1;
         end else if (slot_end_w && st_q == M_BYTE && !ack_bit_w) begin
            bit_q <= bit_q + 4'h1;
            sh_q <= rx_kind_w ? {sh_q[6:0], sda_s_q} : {sh_q[6:0], 1'b0};
         end else if (slot_end_w && st_q == M_BYTE) begin
            bit_q <= 4'h0;
            st_q <= M_STOP;
            unique case (kind_q)
               K_ADDRW: begin
                  if (!peer_ack_w) begin
                     rsp_nack <= 1'b1;
                  end else if (setp_q) begin
                     st_q <= M_BYTE;
                     kind_q <= K_PTR;
                     sh_q <= {6'h00, ptr_q};
                  end else if (left_q != 2'h0) begin
                     st_q <= M_BYTE;
                     kind_q <= K_WDATA;
                     sh_q <= wdata_q[15:8];
                     wdata_q <= {wdata_q[7:0], 8'h00};
                  end
               end
               K_PTR: begin
                  if (!peer_ack_w) begin
                     rsp_nack <= 1'b1;
                  end else if (rd_q) begin
                     st_q <= M_START;
                     rstart_q <= 1'b1;
                  end else if (left_q != 2'h0) begin
                     st_q <= M_BYTE;
                     kind_q <= K_WDATA;
                     sh_q <= wdata_q[15:8];
                     wdata_q <= {wdata_q[7:0], 8'h00};
                  end
               end
               K_WDATA: begin
                  left_q <= left_q - 2'h1;
                  if (!peer_ack_w) begin
                     rsp_nack <= 1'b1;
                  end else if (left_q != 2'h1) begin
                     st_q <= M_BYTE;
                     sh_q <= wdata_q[15:8];
                     wdata_q <= {wdata_q[7:0], 8'h00};
                  end
               end
               K_ADDRR: begin
                  if (!peer_ack_w) begin
                     rsp_nack <= 1'b1;
                  end else if (left_q != 2'h0) begin
                     st_q <= M_BYTE;
                     kind_q <= K_RDATA;
                  end
               end
               K_RDATA: begin
                  rsp_rdata <= {rsp_rdata[7:0], sh_q};
                  left_q <= left_q - 2'h1;
                  if (!last_rd_w) begin
                     st_q <= M_BYTE;
                  end
               end
            endcase
         end
      end
   end

endmodule

// file: thermal_sensor_twowire_slave.sv
`timescale 1ns/1ps
module thermal_sensor_twowire_slave
   import tsense_pkg::*;
(
   // Sampling clock and reset
   input wire logic sample_clk,
   input wire logic nrst,
   // Bus
   twowire_if.sensor bus,
   // Strap pins
   input wire logic address_select_high,
   input wire logic address_select_mid,
   input wire logic address_select_low,
   // Conversion result
   input wire logic temp_valid,
   input wire logic [8:0] temp_data,
   // Settings
   output logic thermo_mode,
   output logic alarm_polarity,
   output logic fault_count_high,
   output logic fault_count_low,
   output logic shutdown,
   output logic [15:0] upper_trip_point,
   output logic [15:0] lower_trip_point,
   output logic [1:0] pointer
);

   typedef enum {SL_IDLE, SL_ADDR, SL_PTR, SL_DATA, SL_TX, SL_IGNORE}
      slv_t;

   slv_t st_q;
   logic scl_m_q, scl_s_q, scl_p_q;
   logic sda_m_q, sda_s_q, sda_p_q;
   logic [2:0] strap_m_q, strap_s_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic [1:0] idx_q;
   logic m_ack_q;
   logic sda_oe_q;
   logic [4:0] cfg_q;
   logic [7:0] upper_hi_q;
   logic [TEMP_BITS-1:0] temp_q;

   // ------------------------------------------------------------
   // Pin synchronisers and condition detection
   // ------------------------------------------------------------
   always_ff @(posedge sample_clk) begin
      if (!nrst) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
         strap_m_q <= 3'h0;
         strap_s_q <= 3'h0;
      end else begin
         scl_m_q <= bus.scl;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= bus.sda;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
         strap_m_q <= {address_select_high, address_select_mid,
                       address_select_low};
         strap_s_q <= strap_m_q;
      end
   end

   wire scl_hold_w = scl_s_q && scl_p_q;
   wire start_w = scl_hold_w && sda_p_q && !sda_s_q;
   wire stop_w = scl_hold_w && !sda_p_q && sda_s_q;
   wire rise_w = scl_s_q && !scl_p_q;
   wire fall_w = !scl_s_q && scl_p_q;
   wire active_w = (st_q != SL_IDLE) && (st_q != SL_IGNORE);
   wire byte_end_w = fall_w && (cnt_q == 4'h8);
   wire ack_end_w = fall_w && (cnt_q == 4'h9);
   wire addr_hit_w = (sh_q[7:4] == ADDR_PREFIX) &&
                     (sh_q[3:1] == strap_s_q);
   wire wr_w = active_w && byte_end_w && (st_q == SL_DATA);

   // ------------------------------------------------------------
   // Read data selection
   // ------------------------------------------------------------
   function automatic logic [15:0] reg_word(input logic [1:0] p,
      input logic [TEMP_BITS-1:0] t, input logic [15:0] up,
      input logic [15:0] lo);
      logic [15:0] w;
      w = {t, {(16 - TEMP_BITS){1'b0}}};
      unique case (p)
         PTR_TEMP: w = {t, {(16 - TEMP_BITS){1'b0}}};
         PTR_CFG: w = 16'h0000;
         PTR_LOWER: w = lo;
         PTR_UPPER: w = up;
      endcase
      return w;
   endfunction

   wire [15:0] word_w = reg_word(pointer, temp_q, upper_trip_point,
                                 lower_trip_point);
   wire [7:0] cfg_byte_w = {3'h0, cfg_q};
   wire [7:0] tx_byte_w = (pointer == PTR_CFG) ? cfg_byte_w :
                          (idx_q[0] ? word_w[7:0] : word_w[15:8]);
   wire [2:0] tx_sel_w = 3'(3'h7 - cnt_q[2:0]);

   // ------------------------------------------------------------
   // Protocol engine
   // ------------------------------------------------------------
   always_ff @(posedge sample_clk) begin
      if (!nrst) begin
         st_q <= SL_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         idx_q <= 2'h0;
         m_ack_q <= 1'b0;
         sda_oe_q <= 1'b0;
         pointer <= PTR_RESET;
      end else if (start_w) begin
         st_q <= SL_ADDR;
         cnt_q <= 4'h0;
         idx_q <= 2'h0;
         sda_oe_q <= 1'b0;
      end else if (stop_w) begin
         st_q <= SL_IDLE;
         sda_oe_q <= 1'b0;
      end else if (active_w && rise_w) begin
         if (cnt_q < 4'h8) begin
            sh_q <= {sh_q[6:0], sda_s_q};
         end else begin
            m_ack_q <= !sda_s_q;
         end
         cnt_q <= cnt_q + 4'h1;
      end else if (active_w && byte_end_w) begin
         unique case (st_q)
            SL_ADDR: begin
               if (addr_hit_w) begin
                  sda_oe_q <= 1'b1;
                  st_q <= sh_q[0] ? SL_TX : SL_PTR;
               end else begin
                  st_q <= SL_IGNORE;
               end
            end
            SL_PTR: begin
               pointer <= sh_q[1:0];
               sda_oe_q <= 1'b1;
               st_q <= SL_DATA;
               idx_q <= 2'h0;
            end
            SL_DATA: begin
               sda_oe_q <= 1'b1;
               if (idx_q != 2'h2) begin
                  idx_q <= idx_q + 2'h1;
               end
            end
            SL_TX: begin
               sda_oe_q <= 1'b0;
               idx_q <= idx_q + 2'h1;
            end
            default: begin
               sda_oe_q <= 1'b0;
            end
         endcase
      end else if (active_w && ack_end_w) begin
         cnt_q <= 4'h0;
         if (st_q != SL_TX) begin
            sda_oe_q <= 1'b0;
         end else if (m_ack_q) begin
            sda_oe_q <= !tx_byte_w[7];
         end else begin
            st_q <= SL_IGNORE;
            sda_oe_q <= 1'b0;
         end
      end else if (active_w && fall_w && st_q == SL_TX) begin
         sda_oe_q <= !tx_byte_w[tx_sel_w];
      end
   end

   assign bus.sda_s_o = 1'b0;
   assign bus.sda_s_oe = sda_oe_q;

   // ------------------------------------------------------------
   // Settings and temperature
   // ------------------------------------------------------------
   always_ff @(posedge sample_clk) begin
      if (!nrst) begin
         cfg_q <= CFG_RESET;
         upper_trip_point <= UPPER_RESET;
         lower_trip_point <= LOWER_RESET;
         upper_hi_q <= 8'h00;
      end else if (wr_w) begin
         unique case (pointer)
            PTR_CFG: begin
               if (idx_q == 2'h0) begin
                  cfg_q <= sh_q[4:0];
               end
            end
            PTR_UPPER, PTR_LOWER: begin
               if (idx_q == 2'h0) begin
                  upper_hi_q <= sh_q;
               end else if (idx_q == 2'h1 && pointer == PTR_UPPER) begin
                  upper_trip_point <= {upper_hi_q, sh_q};
               end else if (idx_q == 2'h1) begin
                  lower_trip_point <= {upper_hi_q, sh_q};
               end
            end
            PTR_TEMP: begin
               upper_hi_q <= upper_hi_q;
            end
         endcase
      end
   end

   // Conversion result held while a read is under way
   always_ff @(posedge sample_clk) begin
      if (!nrst) begin
         temp_q <= '0;
      end else if (temp_valid && st_q != SL_TX) begin
         temp_q <= temp_data;
      end
   end

   assign shutdown = cfg_q[CFG_SHUTDOWN_BIT];
   assign thermo_mode = cfg_q[CFG_MODE_BIT];
   assign alarm_polarity = cfg_q[CFG_POLARITY_BIT];
   assign fault_count_low = cfg_q[CFG_FAULT_LOW_BIT];
   assign fault_count_high = cfg_q[CFG_FAULT_HIGH_BIT];

endmodule

// file: twowire_link_asserts.sv
`timescale 1ns/1ps
module twowire_link_asserts
   import tsense_pkg::*;
(
   // Clocks and reset
   input wire logic mclk,
   input wire logic sample_clk,
   input wire logic nrst,
   // Wire drivers and levels
   input wire logic sda_m_oe,
   input wire logic sda_s_oe,
   input wire logic scl,
   input wire logic sda,
   // Strap pins
   input wire logic address_select_high,
   input wire logic address_select_mid,
   input wire logic address_select_low
);
   // ------------------------------------------------------------
   // Bus tracking
   // ------------------------------------------------------------
   logic scl_q, sda_q, frame_q, frame_d;
   logic [3:0] bit_q, bit_d;
   logic [1:0] byte_q, byte_d;
   logic [7:0] shift_q, shift_d, addr_q, addr_d;
   logic scl_rise, start_det, stop_det, ninth, addr_hit, addressed;
   logic [6:0] own_addr;

   assign own_addr = {ADDR_PREFIX, address_select_high, address_select_mid,
      address_select_low};
   assign scl_rise = scl && !scl_q;
   assign start_det = scl && scl_q && sda_q && !sda;
   assign stop_det = scl && scl_q && !sda_q && sda;
   assign ninth = scl_rise && bit_q == 4'h8;
   assign addr_hit = shift_q[7:1] == own_addr;
   assign addressed = addr_q[7:1] == own_addr;
   assign frame_d = start_det ? 1'b1 : (stop_det ? 1'b0 : frame_q);
   assign bit_d = start_det ? 4'h0 : (!scl_rise ? bit_q :
      (bit_q == 4'h9 ? 4'h1 : bit_q + 4'h1));
   assign byte_d = start_det ? 2'h0 :
      ((ninth && byte_q != 2'h3) ? byte_q + 2'h1 : byte_q);
   assign shift_d = (scl_rise && bit_q < 4'h8) ? {shift_q[6:0], sda} : shift_q;
   assign addr_d = (ninth && byte_q == 2'h0) ? shift_q : addr_q;

   always_ff @(posedge mclk) begin
      scl_q <= scl;
      sda_q <= sda;
      shift_q <= shift_d;
      addr_q <= addr_d;
      frame_q <= nrst ? frame_d : 1'b0;
      bit_q <= nrst ? bit_d : 4'h0;
      byte_q <= nrst ? byte_d : 2'h0;
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   sequence s_addr_bit;
      ninth && byte_q == 2'h0;
   endsequence
   sequence s_read_nack;
      ninth && byte_q != 2'h0 && addr_q[0] && sda;
   endsequence

   property p_addr_ack;
      @(posedge mclk) disable iff (!nrst) s_addr_bit |-> sda_s_oe == addr_hit;
   endproperty
   property p_rx_ack;
      @(posedge mclk) disable iff (!nrst)
         ninth && byte_q != 2'h0 && !addr_q[0] && addressed |-> sda_s_oe;
   endproperty
   property p_rx_quiet;
      @(posedge mclk) disable iff (!nrst)
         ninth && byte_q != 2'h0 && (addr_q[0] || !addressed) |-> !sda_s_oe;
   endproperty
   property p_nack_release;
      @(posedge mclk) disable iff (!nrst)
         s_read_nack |=> !sda_s_oe until stop_det;
   endproperty
   property p_stop_bound;
      @(posedge mclk) disable iff (!nrst) s_read_nack |-> ##[1:400] stop_det;
   endproperty
   property p_frame_len;
      @(posedge mclk) disable iff (!nrst)
         (start_det && frame_q) || stop_det |->
            bit_q == 4'h1 && byte_q != 2'h0;
   endproperty
   property p_master_hold;
      @(posedge mclk) disable iff (!nrst)
         scl && scl_q && sda_m_oe != $past(sda_m_oe) |-> start_det || stop_det;
   endproperty
   property p_sensor_hold;
      @(posedge sample_clk) disable iff (!nrst) $changed(sda_s_oe) |-> !scl;
   endproperty
   property p_stop_quiet;
      @(posedge sample_clk) disable iff (!nrst)
         scl && $rose(sda) |=> !sda_s_oe [*8];
   endproperty

   a_addr_ack: assert property (p_addr_ack)
      else $error("address acknowledge wrong");
   a_rx_ack: assert property (p_rx_ack)
      else $error("received byte not acknowledged");
   a_rx_quiet: assert property (p_rx_quiet)
      else $error("sensor drove master acknowledge slot");
   a_nack_release: assert property (p_nack_release)
      else $error("sensor drove data after final byte");
   a_stop_bound: assert property (p_stop_bound)
      else $error("no stop after final byte");
   a_frame_len: assert property (p_frame_len)
      else $error("frame ended inside a byte");
   a_master_hold: assert property (p_master_hold)
      else $error("master moved data with clock high");
   a_sensor_hold: assert property (p_sensor_hold)
      else $error("sensor moved data with clock high");
   a_stop_quiet: assert property (p_stop_quiet)
      else $error("sensor active on idle bus");
endmodule

// file: thermal_sensor_twowire_slave_tb.sv
`timescale 1ns/1ps
module thermal_sensor_twowire_slave_tb
   import tsense_pkg::*;
;
   logic mclk, sample_clk, nrst, cmd_valid, cmd_ready, cmd_read, cmd_set_ptr;
   logic [1:0] cmd_pointer, cmd_nbytes, pointer, exp_ptr;
   logic [2:0] cmd_target, straps;
   logic [15:0] cmd_wdata, rsp_rdata, upper_trip_point, lower_trip_point;
   logic [15:0] exp_up, exp_lo;
   logic rsp_valid, rsp_nack, temp_valid, thermo_mode, alarm_polarity;
   logic fault_count_high, fault_count_low, shutdown;
   logic [8:0] temp_data, exp_temp;
   logic [4:0] cfg_out, exp_cfg;
   int n_mismatch, comparisons;

   twowire_if bus_if();
   twowire_master twowire_master_i (
      .mclk, .nrst, .bus(bus_if), .cmd_valid, .cmd_ready, .cmd_read,
      .cmd_set_ptr, .cmd_pointer, .cmd_target, .cmd_nbytes, .cmd_wdata,
      .rsp_valid, .rsp_rdata, .rsp_nack
   );
   thermal_sensor_twowire_slave thermal_sensor_twowire_slave_i (
      .sample_clk, .nrst, .bus(bus_if), .address_select_high(straps[2]),
      .address_select_mid(straps[1]), .address_select_low(straps[0]),
      .temp_valid, .temp_data, .thermo_mode, .alarm_polarity,
      .fault_count_high, .fault_count_low, .shutdown, .upper_trip_point,
      .lower_trip_point, .pointer
   );
   twowire_link_asserts twowire_link_asserts_i (
      .mclk, .sample_clk, .nrst, .sda_m_oe(bus_if.sda_m_oe),
      .sda_s_oe(bus_if.sda_s_oe), .scl(bus_if.scl), .sda(bus_if.sda),
      .address_select_high(straps[2]), .address_select_mid(straps[1]),
      .address_select_low(straps[0])
   );
   assign cfg_out = {fault_count_high, fault_count_low, alarm_polarity,
      thermo_mode, shutdown};

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      sample_clk = 1'b0;
      #7;
      forever #16 sample_clk = ~sample_clk;
   end

   // ------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic hung();
      n_mismatch++;
      $display("unexpected handshake: expected 1, seen 0");
      stop_test();
   endtask
   function automatic logic [15:0] reg_word(input logic [1:0] p);
      case (p)
         PTR_TEMP: return {exp_temp, 7'h00};
         PTR_CFG: return {3'h0, exp_cfg, 3'h0, exp_cfg};
         PTR_LOWER: return exp_lo;
         default: return exp_up;
      endcase
   endfunction
   task automatic check_regs();
      check("config", {11'h000, exp_cfg}, {11'h000, cfg_out});
      check("upper", exp_up, upper_trip_point);
      check("lower", exp_lo, lower_trip_point);
      check("pointer", {14'h0000, exp_ptr}, {14'h0000, pointer});
   endtask

   // ------------------------------------------------------------
   // Stimulus tasks
   // ------------------------------------------------------------
   task automatic reset_dut();
      @(posedge mclk);
      nrst <= 1'b0;
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      exp_ptr = 2'h0;
      exp_cfg = 5'h00;
      exp_up = 16'h5000;
      exp_lo = 16'h4B00;
      exp_temp = 9'h000;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic do_cmd(input logic rd, input logic sp, input logic [1:0] p,
      input logic [2:0] tgt, input logic [1:0] nb, input logic [15:0] wd);
      int n;
      @(posedge mclk);
      cmd_read <= rd;
      cmd_set_ptr <= sp;
      cmd_pointer <= p;
      cmd_target <= tgt;
      cmd_nbytes <= nb;
      cmd_wdata <= wd;
      cmd_valid <= 1'b1;
      @(negedge mclk);
      for (n = 0; cmd_ready !== 1'b1 && n < 20; n++) @(negedge mclk);
      if (cmd_ready !== 1'b1) hung();
      @(posedge mclk);
      cmd_valid <= 1'b0;
      for (n = 0; rsp_valid !== 1'b1 && n < 8000; n++) @(negedge mclk);
      if (rsp_valid !== 1'b1) hung();
   endtask
   task automatic load_temp(input logic [8:0] t);
      @(posedge sample_clk);
      temp_data <= t;
      temp_valid <= 1'b1;
      @(posedge sample_clk);
      temp_valid <= 1'b0;
      exp_temp = t;
   endtask
   task automatic read_reg(input logic sp, input logic [1:0] p,
      input logic [1:0] nb);
      logic [15:0] w;
      w = reg_word(p);
      do_cmd(1'b1, sp, p, straps, nb, 16'h0000);
      exp_ptr = p;
      check("read nack", 16'h0000, {15'h0000, rsp_nack});
      if (nb == 2'h1) begin
         check("read byte", {8'h00, w[15:8]}, {8'h00, rsp_rdata[7:0]});
      end else begin
         check("read word", w, rsp_rdata);
      end
   endtask
   task automatic write_reg(input logic [1:0] p, input logic [1:0] nb,
      input logic [15:0] d);
      do_cmd(1'b0, 1'b1, p, straps, nb, d);
      exp_ptr = p;
      if (p == PTR_CFG) exp_cfg = d[12:8];
      if (p == PTR_LOWER) exp_lo = d;
      if (p == PTR_UPPER) exp_up = d;
      check("write nack", 16'h0000, {15'h0000, rsp_nack});
      check_regs();
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [4:0] cfg;
      logic [1:0] p;
      int i;
      void'($urandom(80));
      straps = 3'($urandom);
      nrst = 1'b0;
      {cmd_valid, cmd_read, cmd_set_ptr, temp_valid} = 4'h0;
      {cmd_pointer, cmd_nbytes, cmd_target} = 7'h00;
      cmd_wdata = 16'h0000;
      temp_data = 9'h000;
      reset_dut();
      check_regs();
      load_temp(9'($urandom));
      read_reg(1'b0, exp_ptr, 2'h2);
      for (i = 0; i < 8; i++) begin
         p = 2'($urandom);
         do_cmd(1'b0, 1'b1, p, 3'(i), 2'h0, 16'h0000);
         if (3'(i) == straps) exp_ptr = p;
         check("nack", {15'h0000, 3'(i) != straps}, {15'h0000, rsp_nack});
         check_regs();
      end
      for (i = 0; i < 4; i++) begin
         cfg = 5'($urandom);
         cfg[CFG_MODE_BIT] = i[0];
         write_reg(PTR_CFG, 2'h1, {3'h0, cfg, 8'h00});
         read_reg(1'b0, PTR_CFG, 2'($urandom_range(1, 2)));
      end
      for (i = 0; i < 4; i++) begin
         p = i[0] ? PTR_UPPER : PTR_LOWER;
         write_reg(p, 2'h2, {9'($urandom), 7'h00});
         load_temp(9'($urandom));
         read_reg(1'b1, PTR_TEMP, 2'h2);
         read_reg(1'b1, p, 2'h2);
      end
      write_reg(PTR_TEMP, 2'h2, 16'hA5A5);
      read_reg(1'b0, PTR_TEMP, 2'h2);
      reset_dut();
      check_regs();
      read_reg(1'b0, exp_ptr, 2'h2);
      stop_test();
   end
endmodule
